// ---- rtl/shs_homing.sv ----
// Module: homing sequencer top with register port and sensor inputs
//
// Function
// - Successful search loads zero into profile position
// - Encoder position loaded same value, same update
// - Final segment at one tenth programmed speed
// - Preset loads host value; host keeps range
// - Clockwise search starts and ends clockwise
// - Counter-clockwise search mirrors clockwise sequence
// - Run out until home, stop, pause
// - Reverse until home inactive, stop, pause
// - Creep back, stop on home activation
// - Home active at start: begin reverse run
// - Travel limit: immediate-rate stop, pause, reverse
// - Zero immediate decel halts without ramp
// - Search limit active at start: reverse
// - Opposite limit: immediate stop, input error
// - Hold aborts with programmed decel, no resume
// - Immediate stop command or estop edge stops
// - Searches allowed without any limits configured
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module shs_homing #(
  parameter int CYCLES_PER_MS = shs_pkg::CYC_PER_MS,
  parameter int PAUSE_MS      = shs_pkg::PAUSE_MS
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata_q,
  input  wire logic        home_in,
  input  wire logic        cw_limit_in,
  input  wire logic        ccw_limit_in,
  input  wire logic        estop_in,
  input  wire logic        motion_stopped,
  output logic             motion_run_q,
  output logic             motion_dir_cw_q,
  output logic      [31:0] motion_speed_q,
  output logic      [31:0] motion_decel_q,
  output logic             motion_halt_q,
  output logic             prof_pos_load_q,
  output logic             enc_pos_load_q,
  output logic      [31:0] pos_value_q
);

  shs_pause_if pause_bus ();
  shs_pause_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS),
    .PAUSE_MS      (PAUSE_MS)
  ) u_pause (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pause    (pause_bus.tmr)
  );
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic        home_prev_q;
  logic        estop_prev_q;
  logic [3:0]  cfg_q;
  logic [31:0] speed_q;
  logic [31:0] decel_q;
  logic [31:0] istop_decel_q;
  logic [31:0] preset_q;
  logic        homed_q;
  logic        input_err_q;
  logic        cmd_err_q;
  logic        input_err_set_q;
  logic        cmd_err_set_q;
  logic        pause_start_q;
  logic        seen_q;
  logic        search_cw_q;
  shs_pkg::shs_state_t state_q;

  logic        home_s;
  logic        cw_lim_s;
  logic        ccw_lim_s;
  logic        estop_rise;
  logic        wr_ctrl;
  logic        cmd_cw;
  logic        cmd_ccw;
  logic        cmd_hold;
  logic        cmd_istop;
  logic        cmd_preset;
  logic        fwd_lim;
  logic        opp_lim;
  logic        start_fwd_lim;
  logic        err_clear_in;
  logic        err_clear_cmd;
  logic [31:0] homing_speed;

  assign pause_bus.start = pause_start_q;
  // Two-stage synchronisers for the sensor pins, then edge history of home and estop
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_q      <= 4'h0;
      sync2_q      <= 4'h0;
      home_prev_q  <= 1'b0;
      estop_prev_q <= 1'b0;
    end else begin
      sync1_q      <= {estop_in, ccw_limit_in, cw_limit_in, home_in};
      sync2_q      <= sync1_q;
      home_prev_q  <= home_s;
      estop_prev_q <= sync2_q[3];
    end
  end

  // Inputs qualified by configuration; unconfigured limits never act
  assign home_s     = sync2_q[0] & cfg_q[shs_pkg::CFG_HOME_EN];
  assign cw_lim_s   = sync2_q[1] & cfg_q[shs_pkg::CFG_CW_LIM_EN];
  assign ccw_lim_s  = sync2_q[2] & cfg_q[shs_pkg::CFG_CCW_LIM_EN];
  assign estop_rise = sync2_q[3] & ~estop_prev_q & cfg_q[shs_pkg::CFG_ESTOP_EN];
  // Limits seen relative to the requested search direction, not the current travel
  assign fwd_lim       = search_cw_q ? cw_lim_s : ccw_lim_s;
  assign opp_lim       = search_cw_q ? ccw_lim_s : cw_lim_s;
  assign start_fwd_lim = cmd_cw ? cw_lim_s : ccw_lim_s;

  // One-cycle command pulses from a write to the command register
  assign wr_ctrl    = reg_wr & (reg_addr == shs_pkg::REG_CTRL);
  assign cmd_cw     = wr_ctrl & reg_wdata[shs_pkg::CTRL_CW_SEARCH];
  assign cmd_ccw    = wr_ctrl & reg_wdata[shs_pkg::CTRL_CCW_SEARCH] & ~cmd_cw;
  assign cmd_hold   = wr_ctrl & reg_wdata[shs_pkg::CTRL_HOLD];
  assign cmd_istop  = wr_ctrl & reg_wdata[shs_pkg::CTRL_ISTOP];
  assign cmd_preset = wr_ctrl & reg_wdata[shs_pkg::CTRL_PRESET];

  // Write-one-to-clear of the sticky error flags
  assign err_clear_in  = reg_wr & (reg_addr == shs_pkg::REG_STATUS)
                         & reg_wdata[shs_pkg::STS_INPUT_ERR];
  assign err_clear_cmd = reg_wr & (reg_addr == shs_pkg::REG_STATUS)
                         & reg_wdata[shs_pkg::STS_CMD_ERR];

  // Final segment speed
  assign homing_speed = speed_q / shs_pkg::HOMING_DIVISOR;
  // Stop ramp for an immediate stop; zero means no ramp at all
  function automatic logic istop_no_ramp(input logic [31:0] rate);
    istop_no_ramp = (rate == 32'h0000_0000);
  endfunction

  // Writable parameter registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_q         <= shs_pkg::CFG_RESET;
      speed_q       <= shs_pkg::SPEED_RESET;
      decel_q       <= shs_pkg::DECEL_RESET;
      istop_decel_q <= shs_pkg::DECEL_RESET;
      preset_q      <= shs_pkg::PRESET_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        shs_pkg::REG_CONFIG:      cfg_q         <= reg_wdata[3:0];
        shs_pkg::REG_SPEED:       speed_q       <= reg_wdata;
        shs_pkg::REG_DECEL:       decel_q       <= reg_wdata;
        shs_pkg::REG_ISTOP_DECEL: istop_decel_q <= reg_wdata;
        shs_pkg::REG_PRESET:      preset_q      <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data, valid the cycle after the read strobe only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        shs_pkg::REG_CONFIG:      reg_rdata_q <= {28'h0000000, cfg_q};
        shs_pkg::REG_SPEED:       reg_rdata_q <= speed_q;
        shs_pkg::REG_DECEL:       reg_rdata_q <= decel_q;
        shs_pkg::REG_ISTOP_DECEL: reg_rdata_q <= istop_decel_q;
        shs_pkg::REG_PRESET:      reg_rdata_q <= preset_q;
        shs_pkg::REG_STATUS:      reg_rdata_q <= {24'h000000, 4'(state_q), cmd_err_q,
                                                  input_err_q, homed_q,
                                                  (state_q != shs_pkg::ST_IDLE)};
        shs_pkg::REG_INPUTS:      reg_rdata_q <= {28'h0000000, sync2_q};
        default:                  reg_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  // Sticky error flags; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      input_err_q <= 1'b0;
      cmd_err_q   <= 1'b0;
    end else begin
      input_err_q <= input_err_set_q | (input_err_q & ~err_clear_in);
      cmd_err_q   <= cmd_err_set_q | (cmd_err_q & ~err_clear_cmd);
    end
  end

  // Homing sequencer and motion command outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q         <= shs_pkg::ST_IDLE;
      seen_q          <= 1'b0;
      search_cw_q     <= 1'b1;
      homed_q         <= 1'b0;
      motion_run_q    <= 1'b0;
      motion_dir_cw_q <= 1'b1;
      motion_speed_q  <= 32'h0000_0000;
      motion_decel_q  <= 32'h0000_0000;
      motion_halt_q   <= 1'b0;
      prof_pos_load_q <= 1'b0;
      enc_pos_load_q  <= 1'b0;
      pos_value_q     <= 32'h0000_0000;
      pause_start_q   <= 1'b0;
      input_err_set_q <= 1'b0;
      cmd_err_set_q   <= 1'b0;
    end else begin
      prof_pos_load_q <= 1'b0;
      enc_pos_load_q  <= 1'b0;
      motion_halt_q   <= 1'b0;
      pause_start_q   <= 1'b0;
      input_err_set_q <= 1'b0;
      cmd_err_set_q   <= 1'b0;
      if (state_q == shs_pkg::ST_IDLE) begin
        if (cmd_preset) begin
          prof_pos_load_q <= 1'b1;
          enc_pos_load_q  <= 1'b1;
          pos_value_q     <= preset_q;
        end else if (cmd_cw | cmd_ccw) begin
          if (!cfg_q[shs_pkg::CFG_HOME_EN]) begin
            cmd_err_set_q <= 1'b1;
          end else begin
            homed_q         <= 1'b0;
            search_cw_q     <= cmd_cw;
            motion_dir_cw_q <= cmd_cw;
            motion_speed_q  <= speed_q;
            motion_decel_q  <= decel_q;
            motion_run_q    <= 1'b1;
            if (home_s) begin
              motion_dir_cw_q <= ~cmd_cw;
              seen_q          <= 1'b1;
              state_q         <= shs_pkg::ST_REV_RUN;
            end else if (start_fwd_lim) begin
              motion_dir_cw_q <= ~cmd_cw;
              seen_q          <= 1'b0;
              state_q         <= shs_pkg::ST_REV_RUN;
            end else begin
              state_q <= shs_pkg::ST_FWD_RUN;
            end
          end
        end
      end else if ((cmd_istop | estop_rise | opp_lim) && (state_q != shs_pkg::ST_ABORT)) begin
        motion_run_q   <= 1'b0;
        motion_decel_q <= istop_decel_q;
        motion_halt_q  <= istop_no_ramp(istop_decel_q);
        input_err_set_q <= opp_lim & ~cmd_istop & ~estop_rise;
        state_q        <= shs_pkg::ST_ABORT;
      end else if (cmd_hold && (state_q != shs_pkg::ST_ABORT)) begin
        motion_run_q   <= 1'b0;
        motion_decel_q <= decel_q;
        state_q        <= shs_pkg::ST_ABORT;
      end else begin
        unique case (state_q)
          shs_pkg::ST_FWD_RUN: begin
            if (fwd_lim) begin
              motion_run_q   <= 1'b0;
              motion_decel_q <= istop_decel_q;
              motion_halt_q  <= istop_no_ramp(istop_decel_q);
              state_q        <= shs_pkg::ST_LIM_STOP;
            end else if (home_s) begin
              motion_run_q <= 1'b0;
              state_q      <= shs_pkg::ST_FWD_STOP;
            end
          end
          shs_pkg::ST_FWD_STOP, shs_pkg::ST_LIM_STOP: begin
            if (motion_stopped) begin
              pause_start_q <= 1'b1;
              state_q       <= shs_pkg::ST_PAUSE_A;
            end
          end
          shs_pkg::ST_PAUSE_A: begin
            if (pause_bus.done) begin
              motion_dir_cw_q <= ~motion_dir_cw_q;
              motion_speed_q  <= speed_q;
              motion_decel_q  <= decel_q;
              motion_run_q    <= 1'b1;
              seen_q          <= 1'b0;
              state_q         <= shs_pkg::ST_REV_RUN;
            end
          end
          shs_pkg::ST_REV_RUN: begin
            if (home_s) begin
              seen_q <= 1'b1;
            end else if (seen_q) begin
              motion_run_q <= 1'b0;
              state_q      <= shs_pkg::ST_REV_STOP;
            end
          end
          shs_pkg::ST_REV_STOP: begin
            if (motion_stopped) begin
              pause_start_q <= 1'b1;
              state_q       <= shs_pkg::ST_PAUSE_B;
            end
          end
          shs_pkg::ST_PAUSE_B: begin
            if (pause_bus.done) begin
              motion_dir_cw_q <= ~motion_dir_cw_q;
              motion_speed_q  <= homing_speed;
              motion_decel_q  <= decel_q;
              motion_run_q    <= 1'b1;
              state_q         <= shs_pkg::ST_CREEP;
            end
          end
          shs_pkg::ST_CREEP: begin
            if (fwd_lim) begin
              motion_run_q   <= 1'b0;
              motion_decel_q <= istop_decel_q;
              motion_halt_q  <= istop_no_ramp(istop_decel_q);
              state_q        <= shs_pkg::ST_LIM_STOP;
            end else if (home_s & ~home_prev_q) begin
              motion_run_q    <= 1'b0;
              motion_halt_q   <= 1'b1;
              prof_pos_load_q <= 1'b1;
              enc_pos_load_q  <= 1'b1;
              pos_value_q     <= 32'h0000_0000;
              homed_q         <= 1'b1;
              state_q         <= shs_pkg::ST_IDLE;
            end
          end
          shs_pkg::ST_ABORT: begin
            if (motion_stopped) begin
              state_q <= shs_pkg::ST_IDLE;
            end
          end
          default: state_q <= shs_pkg::ST_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- include/shs_pkg.sv ----
// Package: constants and types for the servo homing sequencer
package shs_pkg;

  // Register byte addresses on the register port
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_CONFIG      = 8'h04;
  localparam logic [7:0] REG_SPEED       = 8'h08;
  localparam logic [7:0] REG_DECEL       = 8'h0C;
  localparam logic [7:0] REG_ISTOP_DECEL = 8'h10;
  localparam logic [7:0] REG_PRESET      = 8'h14;
  localparam logic [7:0] REG_STATUS      = 8'h18;
  localparam logic [7:0] REG_INPUTS      = 8'h1C;

  // Command register bits (write-only, self clearing)
  localparam int CTRL_CW_SEARCH  = 0;
  localparam int CTRL_CCW_SEARCH = 1;
  localparam int CTRL_HOLD       = 2;
  localparam int CTRL_ISTOP      = 3;
  localparam int CTRL_PRESET     = 4;

  // Configuration register bits
  localparam int CFG_HOME_EN    = 0;
  localparam int CFG_CW_LIM_EN  = 1;
  localparam int CFG_CCW_LIM_EN = 2;
  localparam int CFG_ESTOP_EN   = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;

  // Status register bits
  localparam int STS_BUSY      = 0;
  localparam int STS_HOMED     = 1;
  localparam int STS_INPUT_ERR = 2;
  localparam int STS_CMD_ERR   = 3;
  localparam int STS_STATE_LSB = 4;

  // Reset values of the motion parameters
  localparam logic [31:0] SPEED_RESET  = 32'h0000_0000;
  localparam logic [31:0] DECEL_RESET  = 32'h0000_0000;
  localparam logic [31:0] PRESET_RESET = 32'h0000_0000;

  // Homing speed is the programmed speed divided by this
  localparam logic [31:0] HOMING_DIVISOR = 32'h0000_000A;

  // Pause timing
  localparam int PAUSE_MS    = 2000;
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int CYC_PER_MS  = CLK_FREQ_HZ / 1000;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FWD_RUN,
    ST_FWD_STOP,
    ST_LIM_STOP,
    ST_PAUSE_A,
    ST_REV_RUN,
    ST_REV_STOP,
    ST_PAUSE_B,
    ST_CREEP,
    ST_ABORT
  } shs_state_t;

endpackage

// ---- include/shs_pause_if.sv ----
// Interface: pause timer request and completion
`timescale 1ns/100ps
`default_nettype none
interface shs_pause_if;
  logic start;
  logic done;
  modport ctl (output start, input done);
  modport tmr (input start, output done);
endinterface
`default_nettype wire

// ---- rtl/shs_pause_timer.sv ----
// Module: millisecond-scaled pause timer
`timescale 1ns/100ps
`default_nettype none
module shs_pause_timer #(
  parameter int CYCLES_PER_MS = shs_pkg::CYC_PER_MS,
  parameter int PAUSE_MS      = shs_pkg::PAUSE_MS
) (
  input  wire logic  core_clk,
  input  wire logic  sys_rst,
  shs_pause_if.tmr   pause
);

  logic [31:0] cyc_q;
  logic [31:0] ms_q;
  logic        run_q;
  logic        done_q;

  assign pause.done = done_q;

  // Cycle prescaler feeding a millisecond count; start restarts it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cyc_q  <= 32'h0000_0000;
      ms_q   <= 32'h0000_0000;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (pause.start) begin
        cyc_q <= 32'h0000_0000;
        ms_q  <= 32'h0000_0000;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cyc_q == 32'(CYCLES_PER_MS - 1)) begin
          cyc_q <= 32'h0000_0000;
          if (ms_q == 32'(PAUSE_MS - 1)) begin
            run_q  <= 1'b0;
            done_q <= 1'b1;
          end else begin
            ms_q <= ms_q + 32'h0000_0001;
          end
        end else begin
          cyc_q <= cyc_q + 32'h0000_0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- bench/shs_motion_model.sv ----
// Bench model of the profile generator that reports when the shaft is at rest
`timescale 1ns/100ps
`default_nettype none
module shs_motion_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] ramp_len,
  input  wire logic       motion_run_q,
  input  wire logic       motion_halt_q,
  output logic            motion_stopped
);
  logic [3:0] vel_q;

  // Speed held while running, ramps down after, a halt zeroes it at once
  always_ff @(posedge core_clk) begin
    if (sys_rst || motion_halt_q) begin
      vel_q <= 4'h0;
    end else if (motion_run_q) begin
      vel_q <= ramp_len;
    end else if (vel_q != 4'h0) begin
      vel_q <= vel_q - 4'h1;
    end
  end

  // At rest only with no run request and no speed left
  assign motion_stopped = !motion_run_q && (vel_q == 4'h0);
endmodule
`default_nettype wire

// ---- bench/shs_homing_sva.sv ----
// Checker: timing relations at the ports of the homing sequencer
`timescale 1ns/100ps
`default_nettype none
module shs_homing_sva #(
  parameter int CYCLES_PER_MS = shs_pkg::CYC_PER_MS,
  parameter int PAUSE_MS      = shs_pkg::PAUSE_MS
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        cw_limit_in,
  input  wire logic        ccw_limit_in,
  input  wire logic        motion_stopped,
  input  wire logic        motion_run_q,
  input  wire logic        motion_dir_cw_q,
  input  wire logic [31:0] motion_speed_q,
  input  wire logic [31:0] motion_decel_q,
  input  wire logic        motion_halt_q,
  input  wire logic        prof_pos_load_q,
  input  wire logic        enc_pos_load_q,
  input  wire logic [31:0] pos_value_q
);
  localparam int PAUSE_CYC = PAUSE_MS * CYCLES_PER_MS;
  logic [31:0] speed_q, decel_q, istop_q, preset_q, rest_q;
  logic [3:0]  cfg_q;
  logic        cw_cmd_q, ctrl_q, ctrl_wr;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  assign ctrl_wr = reg_wr && (reg_addr == shs_pkg::REG_CTRL);

  // Shadow copies of host settings and a count of cycles spent at rest
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {speed_q, decel_q, istop_q, preset_q, rest_q, cfg_q, cw_cmd_q, ctrl_q} <= '0;
    end else begin
      ctrl_q <= ctrl_wr;
      rest_q <= (motion_stopped && !motion_run_q) ? rest_q + 32'h1 : 32'h0;
      if (reg_wr) begin
        case (reg_addr)
          shs_pkg::REG_CONFIG:      cfg_q <= reg_wdata[3:0];
          shs_pkg::REG_SPEED:       speed_q <= reg_wdata;
          shs_pkg::REG_DECEL:       decel_q <= reg_wdata;
          shs_pkg::REG_ISTOP_DECEL: istop_q <= reg_wdata;
          shs_pkg::REG_PRESET:      preset_q <= reg_wdata;
          shs_pkg::REG_CTRL:        cw_cmd_q <= reg_wdata[0] | (~reg_wdata[1] & cw_cmd_q);
          default:                  ;
        endcase
      end
    end
  end

  property p_load_pair;
    (prof_pos_load_q || enc_pos_load_q) |-> (prof_pos_load_q && enc_pos_load_q);
  endproperty
  a_load_pair: assert property (p_load_pair) else $error("position loads not paired");
  property p_home_zero;
    (prof_pos_load_q && motion_halt_q) |-> (pos_value_q == 32'h0 && !motion_run_q);
  endproperty
  a_home_zero: assert property (p_home_zero) else $error("home load not zero");
  property p_preset;
    (prof_pos_load_q && !motion_halt_q) |-> (pos_value_q == preset_q);
  endproperty
  a_preset: assert property (p_preset) else $error("preset load value wrong");
  property p_creep;
    ($rose(motion_run_q) && !ctrl_q && motion_dir_cw_q == cw_cmd_q)
      |-> (motion_speed_q == speed_q / shs_pkg::HOMING_DIVISOR);
  endproperty
  a_creep: assert property (p_creep) else $error("final segment speed wrong");
  property p_reverse;
    ($rose(motion_run_q) && motion_dir_cw_q != cw_cmd_q) |-> (motion_speed_q == speed_q);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse run speed wrong");
  property p_pause;
    ($rose(motion_run_q) && !ctrl_q) |-> (rest_q >= PAUSE_CYC && rest_q <= PAUSE_CYC + 6);
  endproperty
  a_pause: assert property (p_pause) else $error("pause length wrong");
  property p_limit;
    (motion_run_q && ((motion_dir_cw_q && cw_limit_in && cfg_q[shs_pkg::CFG_CW_LIM_EN])
      || (!motion_dir_cw_q && ccw_limit_in && cfg_q[shs_pkg::CFG_CCW_LIM_EN])))
      |-> ##[1:6] (!motion_run_q && motion_decel_q == istop_q);
  endproperty
  a_limit: assert property (p_limit) else $error("travel limit stop wrong");
  property p_hold;
    (ctrl_wr && reg_wdata[shs_pkg::CTRL_HOLD] && !reg_wdata[shs_pkg::CTRL_ISTOP] && motion_run_q)
      |-> ##[1:3] (!motion_run_q && motion_decel_q == decel_q);
  endproperty
  a_hold: assert property (p_hold) else $error("hold stop wrong");
  property p_istop;
    (ctrl_wr && reg_wdata[shs_pkg::CTRL_ISTOP] && motion_run_q && istop_q == 32'h0)
      |-> ##[1:3] (motion_halt_q && !motion_run_q);
  endproperty
  a_istop: assert property (p_istop) else $error("immediate stop missing halt");
endmodule

bind shs_homing shs_homing_sva #(.CYCLES_PER_MS(CYCLES_PER_MS), .PAUSE_MS(PAUSE_MS)) u_sva (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .cw_limit_in(cw_limit_in), .ccw_limit_in(ccw_limit_in),
  .motion_stopped(motion_stopped), .motion_run_q(motion_run_q),
  .motion_dir_cw_q(motion_dir_cw_q), .motion_speed_q(motion_speed_q),
  .motion_decel_q(motion_decel_q), .motion_halt_q(motion_halt_q),
  .prof_pos_load_q(prof_pos_load_q), .enc_pos_load_q(enc_pos_load_q),
  .pos_value_q(pos_value_q));
`default_nettype wire

// ---- bench/shs_homing_tb.sv ----
// Testbench: directed homing scenarios for the servo homing sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module shs_homing_tb;
  logic        core_clk, sys_rst, reg_wr, reg_rd, home_in, cw_limit_in, ccw_limit_in;
  logic        estop_in, motion_stopped, motion_run_q, motion_dir_cw_q, motion_halt_q;
  logic        prof_pos_load_q, enc_pos_load_q;
  logic [7:0]  reg_addr;
  logic [3:0]  ramp_len;
  logic [31:0] reg_wdata, reg_rdata_q, motion_speed_q, motion_decel_q, pos_value_q, load_val;
  int          num_errors, tests_run, load_cnt, enc_cnt, halt_cnt;

  shs_homing #(.CYCLES_PER_MS(2), .PAUSE_MS(3)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .home_in(home_in),
    .cw_limit_in(cw_limit_in), .ccw_limit_in(ccw_limit_in), .estop_in(estop_in),
    .motion_stopped(motion_stopped), .motion_run_q(motion_run_q),
    .motion_dir_cw_q(motion_dir_cw_q), .motion_speed_q(motion_speed_q),
    .motion_decel_q(motion_decel_q), .motion_halt_q(motion_halt_q),
    .prof_pos_load_q(prof_pos_load_q), .enc_pos_load_q(enc_pos_load_q),
    .pos_value_q(pos_value_q));
  shs_motion_model u_motion (
    .core_clk(core_clk), .sys_rst(sys_rst), .ramp_len(ramp_len), .motion_run_q(motion_run_q),
    .motion_halt_q(motion_halt_q), .motion_stopped(motion_stopped));

  // Clock at 250 MHz
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Record position loads and halt pulses
  always @(posedge core_clk) begin
    if (prof_pos_load_q) begin
      load_cnt++;
      load_val = pos_value_q;
    end
    if (enc_pos_load_q) enc_cnt++;
    if (motion_halt_q) halt_cnt++;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask

  task automatic wait_state(input logic [3:0] code);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(shs_pkg::REG_STATUS, s);
      n++;
    end while (s[7:4] !== code && n < 200);
    `CHK(s[7:4], code)
  endtask

  task automatic wait_stop;
    int n;
    for (n = 0; n < 60 && motion_run_q !== 1'b0; n++) @(posedge core_clk);
    `CHK(motion_run_q, 1'b0)
  endtask

  task automatic t_regs;
    logic [31:0] d;
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, d);
    `CHK(d, 32'h0)
    wr(shs_pkg::REG_CONFIG, 32'h0000_000F);
    rd(shs_pkg::REG_CONFIG, d);
    `CHK(d[3:0], 4'hF)
  endtask

  task automatic t_no_home;
    logic [31:0] s;
    wr(shs_pkg::REG_CONFIG, 32'h0);
    wr(shs_pkg::REG_CTRL, 32'h1);
    repeat (3) @(posedge core_clk);
    `CHK(motion_run_q, 1'b0)
    rd(shs_pkg::REG_STATUS, s);
    `CHK(s[3:0], 4'h8)
    wr(shs_pkg::REG_STATUS, 32'h8);
    rd(shs_pkg::REG_STATUS, s);
    `CHK(s[3], 1'b0)
  endtask

  task automatic t_preset;
    logic [31:0] v [2];
    v = '{32'h3FFF_FFFF, 32'hC000_0000};
    foreach (v[i]) begin
      wr(shs_pkg::REG_PRESET, v[i]);
      wr(shs_pkg::REG_CTRL, 32'h10);
      repeat (2) @(posedge core_clk);
      `CHK(load_val, v[i])
      `CHK(enc_cnt, load_cnt)
    end
  endtask

  task automatic t_search(input logic cw);
    logic [31:0] s;
    int n0;
    n0 = load_cnt;
    ramp_len <= cw ? 4'h0 : 4'h9;
    wr(shs_pkg::REG_CONFIG, 32'h1);
    wr(shs_pkg::REG_SPEED, 32'h0000_0064);
    wr(shs_pkg::REG_CTRL, cw ? 32'h1 : 32'h2);
    wait_state(4'h1);
    `CHK(motion_dir_cw_q, cw)
    `CHK(motion_speed_q, 32'h0000_0064)
    home_in <= 1'b1;
    wait_state(4'h5);
    `CHK(motion_dir_cw_q, ~cw)
    home_in <= 1'b0;
    wait_state(4'h8);
    `CHK(motion_dir_cw_q, cw)
    `CHK(motion_speed_q, 32'h0000_000A)
    home_in <= 1'b1;
    wait_state(4'h0);
    rd(shs_pkg::REG_STATUS, s);
    `CHK(s[1], 1'b1)
    `CHK(load_val, 32'h0)
    `CHK(load_cnt, n0 + 1)
    `CHK(enc_cnt, load_cnt)
    home_in <= 1'b0;
  endtask

  task automatic t_home_hold;
    home_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(shs_pkg::REG_CTRL, 32'h2);
    wait_state(4'h5);
    `CHK(motion_dir_cw_q, 1'b1)
    wr(shs_pkg::REG_DECEL, 32'h0000_0007);
    wr(shs_pkg::REG_CTRL, 32'h4);
    @(posedge core_clk);
    #1;
    `CHK({motion_run_q, motion_decel_q}, {1'b0, 32'h0000_0007})
    wait_state(4'h0);
    repeat (20) @(posedge core_clk);
    `CHK(motion_run_q, 1'b0)
    home_in <= 1'b0;
  endtask

  task automatic t_limits;
    logic [31:0] s;
    int h0;
    wr(shs_pkg::REG_CONFIG, 32'h7);
    wr(shs_pkg::REG_ISTOP_DECEL, 32'h5);
    wr(shs_pkg::REG_CTRL, 32'h1);
    wait_state(4'h1);
    cw_limit_in <= 1'b1;
    wait_stop;
    `CHK(motion_decel_q, 32'h5)
    cw_limit_in <= 1'b0;
    wait_state(4'h5);
    `CHK(motion_dir_cw_q, 1'b0)
    h0 = halt_cnt;
    wr(shs_pkg::REG_ISTOP_DECEL, 32'h0);
    wr(shs_pkg::REG_CTRL, 32'h8);
    wait_state(4'h0);
    `CHK(halt_cnt, h0 + 1)
    wr(shs_pkg::REG_CTRL, 32'h1);
    wait_state(4'h1);
    ccw_limit_in <= 1'b1;
    wait_state(4'h0);
    `CHK(halt_cnt, h0 + 2)
    rd(shs_pkg::REG_STATUS, s);
    `CHK(s[2], 1'b1)
    ccw_limit_in <= 1'b0;
    wr(shs_pkg::REG_STATUS, 32'h4);
    cw_limit_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(shs_pkg::REG_CTRL, 32'h1);
    @(posedge core_clk);
    #1;
    `CHK({motion_run_q, motion_dir_cw_q}, 2'b10)
    cw_limit_in <= 1'b0;
    wr(shs_pkg::REG_CONFIG, 32'hF);
    estop_in <= 1'b1;
    wait_state(4'h0);
    rd(shs_pkg::REG_STATUS, s);
    `CHK(s[2], 1'b0)
    estop_in <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("Comparisons: %0d, mismatches: %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {sys_rst, reg_wr, reg_rd, home_in, cw_limit_in, ccw_limit_in, estop_in} = 7'h40;
    {reg_addr, reg_wdata, ramp_len} = '0;
    {num_errors, tests_run, load_cnt, enc_cnt, halt_cnt} = '0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_no_home;
    t_preset;
    t_search(1'b1);
    t_search(1'b0);
    t_home_hold;
    t_limits;
    tally_and_finish;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    num_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
